// [logic/power_saving_mode_control.sv]
// power saving mode sequencer: idle, stop, power-down and reset startup
module power_saving_mode_control (
   input wire logic clk,
   input wire logic reset_n,
   input wire power_saving_pkg::sfr_req_type sfr_req,
   input wire logic instr_done,
   input wire logic enabled_int_req,
   input wire logic ext_int_pin,
   input wire logic rtc_wake_in,
   input wire logic wdog_reset_in,
   input wire logic slow_rc_oscillator,
   output logic [7:0] sfr_rdata,
   output logic cpu_hold,
   output logic core_reset,
   output logic cpu_clk_enable,
   output logic osc_enable,
   output logic regulator_enable,
   output logic baud_double_select
);

   // reset release through two flip-flops
   logic rst_meta_ff;
   logic rst_n_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   // pin level inputs brought into the core clock domain
   logic ext_int_s;
   logic rtc_wake_s;
   logic wdog_s;
   logic slow_osc_s;

   sync_two_stage u_sync_ext (
      .clk(clk),
      .rst_n(rst_n_ff),
      .async_in(ext_int_pin),
      .sync_out(ext_int_s)
   );

   sync_two_stage u_sync_rtc (
      .clk(clk),
      .rst_n(rst_n_ff),
      .async_in(rtc_wake_in),
      .sync_out(rtc_wake_s)
   );

   sync_two_stage u_sync_wdog (
      .clk(clk),
      .rst_n(rst_n_ff),
      .async_in(wdog_reset_in),
      .sync_out(wdog_s)
   );

   sync_two_stage u_sync_slow (
      .clk(clk),
      .rst_n(rst_n_ff),
      .async_in(slow_rc_oscillator),
      .sync_out(slow_osc_s)
   );

   // rising edges of the slow oscillator and of the watchdog request
   logic slow_osc_d_ff;
   logic wdog_d_ff;
   logic slow_tick;
   logic wdog_event;

   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         slow_osc_d_ff <= 1'b0;
         wdog_d_ff <= 1'b0;
      end else begin
         slow_osc_d_ff <= slow_osc_s;
         wdog_d_ff <= wdog_s;
      end
   end

   assign slow_tick = slow_osc_s && !slow_osc_d_ff;
   assign wdog_event = wdog_s && !wdog_d_ff;

   // register decode
   logic power_control_hit;
   logic ckctl_hit;
   logic power_control_wr;
   logic power_control_bit_wr;
   logic ckctl_wr;
   logic ckctl_bit_wr;

   assign power_control_hit = sfr_req.addr == power_saving_pkg::POWER_CONTROL_ADDR;
   assign ckctl_hit = sfr_req.addr == power_saving_pkg::CLOCK_STOP_CONTROL_ADDR;
   assign power_control_wr = power_control_hit && sfr_req.wr;
   assign power_control_bit_wr = power_control_hit && sfr_req.bit_wr;
   assign ckctl_wr = ckctl_hit && sfr_req.wr;
   assign ckctl_bit_wr = ckctl_hit && sfr_req.bit_wr;

   // sequencer state and registers
   power_saving_pkg::seq_state_type state_ff;
   power_saving_pkg::seq_state_type nxt_state;
   power_saving_pkg::power_control_type power_control_ff;
   power_saving_pkg::power_control_type nxt_power_control;
   logic stop_clock_ff;
   logic nxt_stop_clock;
   logic [7:0] sfr_rdata_ff;
   logic [7:0] nxt_rdata;

   // wake and entry terms
   logic slow_done;
   logic xtal_done;
   logic pd_wake;
   logic enter_pd;
   logic enter_stop;
   logic enter_idle;
   logic idle_exit;
   logic pd_exit;
   logic sfr_clear;

   assign enter_pd = instr_done && stop_clock_ff;
   assign enter_stop = instr_done && power_control_ff.stop_select;
   assign enter_idle = instr_done && power_control_ff.idle_select;
   // rtc wake restarts the oscillator even with its interrupt masked
   assign pd_wake = ext_int_s || rtc_wake_s;
   assign idle_exit = (state_ff == power_saving_pkg::ST_IDLE) && enabled_int_req;
   assign pd_exit = (state_ff == power_saving_pkg::ST_PD_WAKE_XTAL) && xtal_done;
   // watchdog reset wipes the registers in every mode
   assign sfr_clear = wdog_event;

   // next state; watchdog has top priority over every other event
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         power_saving_pkg::ST_BOOT: begin
            nxt_state = power_saving_pkg::ST_RST_SLOW;
         end
         power_saving_pkg::ST_RST_SLOW: begin
            if (slow_done) begin
               nxt_state = power_saving_pkg::ST_RST_XTAL;
            end
         end
         power_saving_pkg::ST_RST_XTAL: begin
            if (xtal_done) begin
               nxt_state = power_saving_pkg::ST_RUN;
            end
         end
         power_saving_pkg::ST_RUN: begin
            if (enter_pd) begin
               nxt_state = power_saving_pkg::ST_PD_GATE;
            end else if (enter_stop) begin
               nxt_state = power_saving_pkg::ST_STOP;
            end else if (enter_idle) begin
               nxt_state = power_saving_pkg::ST_IDLE;
            end
         end
         power_saving_pkg::ST_IDLE: begin
            if (enabled_int_req) begin
               nxt_state = power_saving_pkg::ST_RUN;
            end
         end
         power_saving_pkg::ST_STOP: begin
            nxt_state = power_saving_pkg::ST_STOP;
         end
         // orderly shutdown: clock gate, then oscillator, then regulators
         power_saving_pkg::ST_PD_GATE: begin
            nxt_state = power_saving_pkg::ST_PD_OSC_OFF;
         end
         power_saving_pkg::ST_PD_OSC_OFF: begin
            nxt_state = power_saving_pkg::ST_PD_SLEEP;
         end
         power_saving_pkg::ST_PD_SLEEP: begin
            if (pd_wake) begin
               nxt_state = power_saving_pkg::ST_PD_WAKE_SLOW;
            end
         end
         power_saving_pkg::ST_PD_WAKE_SLOW: begin
            if (slow_done) begin
               nxt_state = power_saving_pkg::ST_PD_WAKE_XTAL;
            end
         end
         power_saving_pkg::ST_PD_WAKE_XTAL: begin
            if (xtal_done) begin
               nxt_state = power_saving_pkg::ST_RUN;
            end
         end
         default: begin
            nxt_state = power_saving_pkg::ST_BOOT;
         end
      endcase
      if (wdog_event) begin
         nxt_state = power_saving_pkg::ST_RST_SLOW;
      end
   end

   // startup counter loads on entry to each waiting state
   logic wdog_restart_ff;
   logic slow_load;
   logic xtal_load;
   logic [3:0] slow_load_val;
   logic [5:0] xtal_load_val;

   assign slow_load = wdog_event || (nxt_state != state_ff &&
      (nxt_state == power_saving_pkg::ST_RST_SLOW || nxt_state == power_saving_pkg::ST_PD_WAKE_SLOW));
   assign xtal_load = nxt_state != state_ff &&
      (nxt_state == power_saving_pkg::ST_RST_XTAL || nxt_state == power_saving_pkg::ST_PD_WAKE_XTAL);

   // external wake is the longer of the two, so it wins when both arrive
   assign slow_load_val = wdog_event ? power_saving_pkg::SLOW_WDOG_CYCLES :
      (state_ff == power_saving_pkg::ST_BOOT) ? power_saving_pkg::SLOW_POR_CYCLES :
      ext_int_s ? power_saving_pkg::SLOW_EXT_INT_CYCLES :
      power_saving_pkg::SLOW_RTC_CYCLES;
   assign xtal_load_val = (nxt_state == power_saving_pkg::ST_RST_XTAL) ?
      power_saving_pkg::XTAL_RESET_CYCLES : power_saving_pkg::XTAL_WAKE_CYCLES;

   startup_counter #(
      .WIDTH(4)
   ) u_slow_count (
      .clk(clk),
      .rst_n(rst_n_ff),
      .load(slow_load),
      .load_val(slow_load_val),
      .step(slow_tick),
      .done(slow_done)
   );

   startup_counter #(
      .WIDTH(6)
   ) u_xtal_count (
      .clk(clk),
      .rst_n(rst_n_ff),
      .load(xtal_load),
      .load_val(xtal_load_val),
      .step(1'b1),
      .done(xtal_done)
   );

   // power control next value; a software set wins over the idle exit clear, the watchdog clear wins over both
   always_comb begin
      nxt_power_control = power_control_ff;
      if (idle_exit) begin
         nxt_power_control.idle_select = 1'b0;
      end
      if (power_control_wr) begin
         nxt_power_control = power_saving_pkg::power_control_type'(sfr_req.wdata &
            power_saving_pkg::POWER_CONTROL_READ_MASK);
      end
      if (power_control_bit_wr && sfr_req.bit_sel != 3'h4 && sfr_req.bit_sel != 3'h5 && sfr_req.bit_sel != 3'h6) begin
         nxt_power_control[sfr_req.bit_sel] = sfr_req.bit_val;
      end
      if (sfr_clear) begin
         nxt_power_control = power_saving_pkg::POWER_CONTROL_RESET;
      end
   end

   // power-down request bit; bit zero is not stored
   always_comb begin
      nxt_stop_clock = stop_clock_ff;
      if (pd_exit) begin
         nxt_stop_clock = 1'b0;
      end
      if (ckctl_wr) begin
         nxt_stop_clock = sfr_req.wdata[power_saving_pkg::STOP_CLOCK_BIT] || nxt_stop_clock && 1'b0;
      end
      if (ckctl_bit_wr && sfr_req.bit_sel == 3'(power_saving_pkg::STOP_CLOCK_BIT)) begin
         nxt_stop_clock = sfr_req.bit_val;
      end
      if (sfr_clear) begin
         nxt_stop_clock = power_saving_pkg::CLOCK_STOP_CONTROL_RESET[power_saving_pkg::STOP_CLOCK_BIT];
      end
   end

   // read data, registered one cycle after the read strobe
   assign nxt_rdata = !sfr_req.rd ? sfr_rdata_ff :
      power_control_hit ? (power_control_ff & power_saving_pkg::POWER_CONTROL_READ_MASK) :
      ckctl_hit ? {6'h00, stop_clock_ff, 1'b0} :
      power_saving_pkg::UNMAPPED_READ;

   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         state_ff <= power_saving_pkg::ST_BOOT;
         power_control_ff <= power_saving_pkg::POWER_CONTROL_RESET;
         stop_clock_ff <= 1'b0;
         sfr_rdata_ff <= power_saving_pkg::UNMAPPED_READ;
      end else begin
         state_ff <= nxt_state;
         power_control_ff <= nxt_power_control;
         stop_clock_ff <= nxt_stop_clock;
         sfr_rdata_ff <= nxt_rdata;
      end
   end

   // output controls decoded from the next state so they line up with it
   logic nxt_hold;
   logic nxt_core_reset;
   logic nxt_clk_en;
   logic nxt_osc_en;
   logic nxt_reg_en;

   // holding the core keeps its program counter, so it resumes after the sleeping instruction
   assign nxt_hold = nxt_state != power_saving_pkg::ST_RUN;
   assign nxt_core_reset = nxt_state == power_saving_pkg::ST_BOOT ||
      nxt_state == power_saving_pkg::ST_RST_SLOW || nxt_state == power_saving_pkg::ST_RST_XTAL;
   // idle and stop keep the core clock; only power-down gates it
   assign nxt_clk_en = nxt_state != power_saving_pkg::ST_PD_GATE &&
      nxt_state != power_saving_pkg::ST_PD_OSC_OFF && nxt_state != power_saving_pkg::ST_PD_SLEEP &&
      nxt_state != power_saving_pkg::ST_PD_WAKE_SLOW && nxt_state != power_saving_pkg::ST_PD_WAKE_XTAL;
   assign nxt_osc_en = nxt_state != power_saving_pkg::ST_PD_OSC_OFF &&
      nxt_state != power_saving_pkg::ST_PD_SLEEP;
   assign nxt_reg_en = nxt_state != power_saving_pkg::ST_PD_SLEEP;

   logic cpu_hold_ff;
   logic core_reset_ff;
   logic cpu_clk_enable_ff;
   logic osc_enable_ff;
   logic regulator_enable_ff;

   // core starts held in reset with power up until the boot sequence ends
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cpu_hold_ff <= 1'b1;
         core_reset_ff <= 1'b1;
         cpu_clk_enable_ff <= 1'b1;
         osc_enable_ff <= 1'b1;
         regulator_enable_ff <= 1'b1;
      end else begin
         cpu_hold_ff <= nxt_hold;
         core_reset_ff <= nxt_core_reset;
         cpu_clk_enable_ff <= nxt_clk_en;
         osc_enable_ff <= nxt_osc_en;
         regulator_enable_ff <= nxt_reg_en;
      end
   end

   assign sfr_rdata = sfr_rdata_ff;
   assign cpu_hold = cpu_hold_ff;
   assign core_reset = core_reset_ff;
   assign cpu_clk_enable = cpu_clk_enable_ff;
   assign osc_enable = osc_enable_ff;
   assign regulator_enable = regulator_enable_ff;
   assign baud_double_select = power_control_ff.baud_double_select;

endmodule

// [logic/power_saving_pkg.sv]
// shared constants and types of the power saving mode control
package power_saving_pkg;

   // special function register addresses
   localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
   localparam logic [7:0] CLOCK_STOP_CONTROL_ADDR = 8'hB6;

   // power control and clock stop control register field positions
   localparam int IDLE_BIT = 0;
   localparam int STOP_BIT = 1;
   localparam int FLAG_ZERO_BIT = 2;
   localparam int FLAG_ONE_BIT = 3;
   localparam int BAUD_BIT = 7;
   localparam int STOP_CLOCK_BIT = 1;

   // reset values and read masks
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
   localparam logic [1:0] CLOCK_STOP_CONTROL_RESET = 2'h0;
   localparam logic [7:0] POWER_CONTROL_READ_MASK = 8'h8F;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // startup counts in slow oscillator cycles (longest of each range)
   localparam logic [3:0] SLOW_POR_CYCLES = 4'hF;
   localparam logic [3:0] SLOW_WDOG_CYCLES = 4'hC;
   localparam logic [3:0] SLOW_EXT_INT_CYCLES = 4'h4;
   localparam logic [3:0] SLOW_RTC_CYCLES = 4'h3;

   // startup counts in crystal cycles (the core clock)
   localparam logic [5:0] XTAL_RESET_CYCLES = 6'h18;
   localparam logic [5:0] XTAL_WAKE_CYCLES = 6'h34;

   // sequencer states
   typedef enum logic [3:0] {
      ST_BOOT,
      ST_RST_SLOW,
      ST_RST_XTAL,
      ST_RUN,
      ST_IDLE,
      ST_STOP,
      ST_PD_GATE,
      ST_PD_OSC_OFF,
      ST_PD_SLEEP,
      ST_PD_WAKE_SLOW,
      ST_PD_WAKE_XTAL
   } seq_state_type;

   // special function register access from the core
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
      logic bit_wr;
      logic [2:0] bit_sel;
      logic bit_val;
   } sfr_req_type;

   // power control register layout
   typedef struct packed {
      logic baud_double_select;
      logic [2:0] reserved;
      logic user_flag_one;
      logic user_flag_zero;
      logic stop_select;
      logic idle_select;
   } power_control_type;

endpackage

// [logic/startup_counter.sv]
// loadable down counter that pulses done after a given number of steps
module startup_counter #(
   parameter int WIDTH = 6
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_val,
   input wire logic step,
   output logic done
);

   logic [WIDTH-1:0] count_ff;
   logic busy_ff;
   logic done_ff;
   logic last_step;

   assign last_step = busy_ff && step && (count_ff <= WIDTH'(1));

   // load wins over a step in the same cycle so a restart is never lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (load) begin
         count_ff <= load_val;
         busy_ff <= 1'b1;
         done_ff <= 1'b0;
      end else begin
         if (busy_ff && step) begin
            count_ff <= count_ff - WIDTH'(1);
         end
         busy_ff <= busy_ff && !last_step;
         done_ff <= last_step;
      end
   end

   assign done = done_ff;

endmodule

// [logic/sync_two_stage.sv]
// two flip-flop synchroniser for a level from outside the clock domain
module sync_two_stage (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic sync_out
);

   logic meta_ff;
   logic sync_ff;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

// [test/core_model.sv]
// core model: register accesses, instruction completion, interrupt level
module core_model (
   input wire logic clk,
   input wire logic [7:0] sfr_rdata,
   output power_saving_pkg::sfr_req_type sfr_req,
   output logic instr_done,
   output logic enabled_int_req
);
   timeunit 1ns;
   timeprecision 1ps;

   // no transmitter and no busy watchdog interface here, so accesses go straight out
   // low-power waits use power-down; stop is entered only to test its exit
   initial begin
      sfr_req = '0;
      instr_done = 1'b0;
      enabled_int_req = 1'b0;
   end

   // every strobe lasts one cycle, launched at the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_req.addr = a;
      sfr_req.wdata = d;
      sfr_req.wr = 1'b1;
      @(negedge clk);
      sfr_req = '0;
   endtask

   task automatic bwr(input logic [2:0] b, input logic v);
      @(negedge clk);
      sfr_req.addr = power_saving_pkg::POWER_CONTROL_ADDR;
      sfr_req.bit_sel = b;
      sfr_req.bit_val = v;
      sfr_req.bit_wr = 1'b1;
      @(negedge clk);
      sfr_req = '0;
   endtask

   // read data is registered, so it is taken one cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      sfr_req.addr = a;
      sfr_req.rd = 1'b1;
      @(negedge clk);
      sfr_req = '0;
      d = sfr_rdata;
   endtask

   task automatic done();
      @(negedge clk);
      instr_done = 1'b1;
      @(negedge clk);
      instr_done = 1'b0;
   endtask

   task automatic irq(input logic v);
      @(negedge clk);
      enabled_int_req = v;
   endtask
endmodule

// [test/power_saving_assertions.sv]
// concurrent checks on the power saving sequencer ports
module power_saving_assertions (
   input wire logic clk,
   input wire logic reset_n,
   input wire power_saving_pkg::sfr_req_type sfr_req,
   input wire logic instr_done,
   input wire logic enabled_int_req,
   input wire logic ext_int_pin,
   input wire logic rtc_wake_in,
   input wire logic wdog_reset_in,
   input wire logic slow_rc_oscillator,
   input wire logic [7:0] sfr_rdata,
   input wire logic cpu_hold,
   input wire logic core_reset,
   input wire logic cpu_clk_enable,
   input wire logic osc_enable,
   input wire logic regulator_enable,
   input wire logic baud_double_select
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned wake_cnt_ff;
   int unsigned rst_cnt_ff;

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // length of the powered but gated wake phase, and of the reset startup
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_cnt_ff <= 0;
         rst_cnt_ff <= 0;
      end else begin
         wake_cnt_ff <= (regulator_enable && !cpu_clk_enable) ? wake_cnt_ff + 1 : 0;
         rst_cnt_ff <= core_reset ? rst_cnt_ff + 1 : 0;
      end
   end

   // shutdown goes clock, then oscillator, then regulators
   property p_pd_entry;
      $fell(cpu_clk_enable) |=> !osc_enable ##1 !regulator_enable;
   endproperty
   a_pd_entry: assert property (p_pd_entry) else $error("power-down shutdown order broken");
   property p_reg_off;
      !regulator_enable |-> !osc_enable && !cpu_clk_enable && cpu_hold;
   endproperty
   a_reg_off: assert property (p_reg_off) else $error("regulators off while clock or core active");
   property p_gate_hold;
      !cpu_clk_enable |-> cpu_hold;
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("core runs with clock gated");
   property p_reset_hold;
      core_reset |-> cpu_hold;
   endproperty
   a_reset_hold: assert property (p_reset_hold) else $error("core released during reset");
   // the handler may not start before the crystal startup has run out
   property p_wake_wait;
      $rose(cpu_clk_enable) && !core_reset |-> wake_cnt_ff >= 52;
   endproperty
   a_wake_wait: assert property (p_wake_wait) else $error("wake shorter than crystal startup");
   property p_reset_len;
      $fell(core_reset) |-> rst_cnt_ff >= 24 && $fell(cpu_hold);
   endproperty
   a_reset_len: assert property (p_reset_len) else $error("reset startup too short");
   property p_b6_read;
      sfr_req.rd && sfr_req.addr == power_saving_pkg::CLOCK_STOP_CONTROL_ADDR
         |=> sfr_rdata[7:2] == 6'h00 && !sfr_rdata[0];
   endproperty
   a_b6_read: assert property (p_b6_read) else $error("clock stop control unused bits not zero");
   property p_power_control_read;
      sfr_req.rd && !sfr_req.wr && !sfr_req.bit_wr && sfr_req.addr == power_saving_pkg::POWER_CONTROL_ADDR
         |=> sfr_rdata[6:4] == 3'h0 && sfr_rdata[7] == $past(baud_double_select);
   endproperty
   a_power_control_read: assert property (p_power_control_read) else $error("power control read mismatch");
endmodule

bind power_saving_mode_control power_saving_assertions chk (.clk, .reset_n, .sfr_req, .instr_done,
   .enabled_int_req, .ext_int_pin, .rtc_wake_in, .wdog_reset_in, .slow_rc_oscillator, .sfr_rdata,
   .cpu_hold, .core_reset, .cpu_clk_enable, .osc_enable, .regulator_enable, .baud_double_select);

// [test/test_power_saving_mode_control.sv]
// self-checking bench for the power saving sequencer
module test_power_saving_mode_control;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, e, g) \
   begin \
      n_tests++; \
      if ((g) !== (e)) begin \
         err_total++; \
         $display("[FAIL] %s expected %h seen %h", n, e, g); \
      end \
   end
   localparam int SLOW = 4; // clk cycles per slow oscillator period
   localparam logic [7:0] PC = power_saving_pkg::POWER_CONTROL_ADDR;
   localparam logic [7:0] CS = power_saving_pkg::CLOCK_STOP_CONTROL_ADDR;
   logic clk = 1'b0;
   logic reset_n;
   logic ext_int_pin;
   logic rtc_wake_in;
   logic wdog_reset_in;
   logic slow_rc_oscillator = 1'b0;
   power_saving_pkg::sfr_req_type sfr_req;
   logic instr_done, enabled_int_req, cpu_hold, core_reset, cpu_clk_enable;
   logic osc_enable, regulator_enable, baud_double_select;
   logic [7:0] sfr_rdata;
   int err_total = 0;
   int n_tests = 0;

   power_saving_mode_control dut (.clk, .reset_n, .sfr_req, .instr_done, .enabled_int_req, .ext_int_pin,
      .rtc_wake_in, .wdog_reset_in, .slow_rc_oscillator, .sfr_rdata, .cpu_hold, .core_reset,
      .cpu_clk_enable, .osc_enable, .regulator_enable, .baud_double_select);
   core_model core (.clk, .sfr_rdata, .sfr_req, .instr_done, .enabled_int_req);

   // crystal clock and an unrelated slow oscillator
   always #12.5 clk = ~clk;
   always #50 slow_rc_oscillator = ~slow_rc_oscillator;

   task automatic end_sim();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // bounded wait for the core to run again, counting falling edges
   task automatic wait_run(output int n);
      n = 0;
      while (cpu_hold !== 1'b0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000) begin
         err_total++;
         $display("[FAIL] wait_run expected 0 seen 1");
      end
   endtask

   task automatic chk_reg(input string n, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      core.rd(a, d);
      `CHK(n, e, d) // register readback
   endtask

   task automatic t_boot();
      int k;
      wait_run(k);
      `CHK("boot_len", 1'b1, (k >= 14 * SLOW + 24 && k <= 15 * SLOW + 40))
      `CHK("boot_core_reset", 1'b0, core_reset)
      chk_reg("power_control_reset", PC, 8'h00);
      chk_reg("clkctl_reset", CS, 8'h00);
   endtask

   task automatic t_regs();
      core.wr(PC, 8'hFF);
      chk_reg("power_control_mask", PC, 8'h8F);
      `CHK("baud_on", 1'b1, baud_double_select)
      core.bwr(3'h3, 1'b0);
      chk_reg("flag_one_clr", PC, 8'h87);
      core.bwr(3'h5, 1'b1);
      chk_reg("reserved_bit", PC, 8'h87);
      core.wr(PC, 8'h00);
      core.bwr(3'h2, 1'b1);
      chk_reg("flag_zero_set", PC, 8'h04);
      `CHK("baud_off", 1'b0, baud_double_select)
      core.wr(CS, 8'h01);
      chk_reg("clkctl_bit0", CS, 8'h00);
      chk_reg("unmapped", 8'h88, 8'h00);
   endtask

   task automatic t_idle();
      int k;
      core.wr(PC, 8'h05);
      core.done();
      repeat (2) @(negedge clk);
      `CHK("idle_hold", 1'b1, cpu_hold)
      repeat (10) @(negedge clk);
      `CHK("idle_clock_on", 1'b1, cpu_clk_enable)
      `CHK("idle_still_held", 1'b1, cpu_hold)
      core.irq(1'b1);
      wait_run(k);
      `CHK("idle_exit_fast", 1'b1, (k <= 5))
      core.irq(1'b0);
      chk_reg("idle_bit_cleared", PC, 8'h04);
   endtask

   // watchdog reset from a held state, then the register contents are gone
   task automatic t_wdog(input string n);
      int k;
      @(negedge clk);
      wdog_reset_in = 1'b1;
      repeat (4) @(negedge clk);
      `CHK(n, 1'b1, core_reset)
      wait_run(k);
      `CHK("wdog_len", 1'b1, (k >= 11 * SLOW + 16 && k <= 12 * SLOW + 36))
      wdog_reset_in = 1'b0;
      chk_reg("wdog_power_control", PC, 8'h00);
      chk_reg("wdog_clkctl", CS, 8'h00);
   endtask

   task automatic t_stop();
      core.wr(PC, 8'h0A);
      core.done();
      repeat (2) @(negedge clk);
      `CHK("stop_hold", 1'b1, cpu_hold)
      core.irq(1'b1);
      ext_int_pin = 1'b1;
      rtc_wake_in = 1'b1;
      repeat (60) @(negedge clk);
      `CHK("stop_ignores_int", 1'b1, cpu_hold)
      core.irq(1'b0);
      ext_int_pin = 1'b0;
      rtc_wake_in = 1'b0;
      t_wdog("stop_wdog");
   endtask

   task automatic t_pd_enter();
      core.wr(CS, 8'h02);
      chk_reg("clkctl_set", CS, 8'h02);
      core.done();
      repeat (4) @(negedge clk);
      `CHK("pd_regulator", 1'b0, regulator_enable)
      `CHK("pd_osc", 1'b0, osc_enable)
   endtask

   // enable level alone must not wake; the rtc wakes with the enable low
   task automatic t_pd(input logic rtc);
      int k;
      int s;
      t_pd_enter();
      core.irq(1'b1);
      repeat (30) @(negedge clk);
      `CHK("pd_no_int_wake", 1'b0, regulator_enable)
      core.irq(1'b0);
      rtc_wake_in = rtc;
      ext_int_pin = !rtc;
      s = rtc ? 3 : 4;
      wait_run(k);
      `CHK("pd_wake_len", 1'b1, (k >= 52 + (s - 1) * SLOW && k <= 52 + s * SLOW + 12))
      rtc_wake_in = 1'b0;
      ext_int_pin = 1'b0;
      chk_reg("pd_bit_cleared", CS, 8'h00);
   endtask

   initial begin
      reset_n = 1'b0;
      ext_int_pin = 1'b0;
      rtc_wake_in = 1'b0;
      wdog_reset_in = 1'b0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      t_boot();
      t_regs();
      t_idle();
      t_stop();
      t_pd(1'b0);
      t_pd(1'b1);
      t_pd_enter();
      t_wdog("pd_wdog");
      end_sim();
   end

   // the whole sequence needs about 600 cycles
   initial begin
      #100000;
      err_total++;
      $display("[FAIL] watchdog expected done seen timeout");
      end_sim();
   end
endmodule
